// [common/axis_cmd_pkg.sv]
// constants for the two-axis step/aux-code/position command block
package axis_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] AXIS_OFS = 8'h04;
  localparam logic [7:0] SLOT_OFS = 8'h08;
  localparam logic [7:0] VALUE_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] ERR_CLR_OFS = 8'h14;
  localparam logic [7:0] STEP_X_OFS = 8'h18;
  localparam logic [7:0] STEP_Y_OFS = 8'h1C;
  localparam logic [7:0] POS_X_OFS = 8'h20;
  localparam logic [7:0] POS_Y_OFS = 8'h24;
  localparam logic [7:0] AUX_NUM_X_OFS = 8'h28;
  localparam logic [7:0] AUX_NUM_Y_OFS = 8'h2C;
  localparam logic [7:0] ERR_X_OFS = 8'h30;
  localparam logic [7:0] ERR_Y_OFS = 8'h34;
  // control register fields
  localparam int CTRL_STEP_BIT = 0;
  localparam int CTRL_CANCEL_BIT = 1;
  localparam int CTRL_PRESET_BIT = 2;
  localparam int CTRL_ADV_BIT = 8;
  // status register fields
  localparam int ST_IERR_BIT = 0;
  localparam int ST_BUSY_LSB = 1;
  localparam int ST_ORIGIN_LSB = 3;
  localparam int ST_AUX_LSB = 5;
  // command indices
  localparam int CMD_STEP = 0;
  localparam int CMD_CANCEL = 1;
  localparam int CMD_PRESET = 2;
  // operand limits and error codes (decimal 441, 442, 451)
  localparam logic [15:0] AXIS_X = 16'h0000;
  localparam logic [15:0] AXIS_Y = 16'h0001;
  localparam logic [15:0] STEP_MIN = 16'h0001;
  localparam logic [15:0] STEP_MAX_STD = 16'h001E;
  localparam logic [15:0] STEP_MAX_ADV = 16'h0050;
  localparam logic [15:0] ERR_STEP_BUSY = 16'h01B9;
  localparam logic [15:0] ERR_STEP_RANGE = 16'h01BA;
  localparam logic [15:0] ERR_PRESET_BUSY = 16'h01C3;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  // reset values
  localparam logic [15:0] STEP_RST = 16'h0001;
  localparam logic [31:0] POS_RST = 32'h0000_0000;
  localparam logic [31:0] HRDATA_RST = 32'h0000_0000;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage

// [hw/axis_cmd.sv]
// step change, aux code cancel and position preset for two axes
//
// Summary of operation
// - each command fires once per rising edge
// - axis 0 or 1, else flag error, suppress
// - step change forces selected axis step number
// - step 1..30 standard, 1..80 advanced mode
// - busy axis on step change: error 441
// - step out of range: error 442
// - cancel clears aux present flag and number
// - preset loads signed 32-bit current position
// - preset accepts full signed 32-bit range
// - preset on unfixed origin marks origin fixed
// - busy axis on preset: error 451
`timescale 1ns/1ps
module axis_cmd #(
  parameter int AUX_W = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [1:0] axis_busy_i,
  input wire logic [1:0] aux_load_i,
  input wire logic [AUX_W-1:0] aux_code_i,
  input wire logic [1:0] origin_lost_i,
  output logic [1:0] aux_code_present_o,
  output logic [1:0] origin_fixed_o
);

  typedef struct packed {
    logic [2:0] cmd;
    logic adv;
    logic [2:0] cmd_prev;
    logic [15:0] axis_select;
    logic [15:0] slot_operand;
    logic [31:0] value_operand;
    logic instr_error_flag;
    logic [1:0][15:0] step;
    logic [1:0][31:0] pos;
    logic [1:0] aux_on;
    logic [1:0][AUX_W-1:0] aux_num;
    logic [1:0] origin;
    logic [1:0][15:0] err;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [2:0] rise;
  logic axis_ok;
  logic sel;
  logic [15:0] step_max;
  logic addr_phase;
  // per axis: an error code was raised this cycle, so a clear must yield
  logic [1:0] err_set;

  assign addr_phase = hsel_i && hready_i &&
                      htrans_i == axis_cmd_pkg::HTRANS_NONSEQ;
  assign rise = s_q.cmd & ~s_q.cmd_prev;
  assign axis_ok = s_q.axis_select == axis_cmd_pkg::AXIS_X ||
                   s_q.axis_select == axis_cmd_pkg::AXIS_Y;
  assign sel = s_q.axis_select[0];
  assign step_max = s_q.adv ? axis_cmd_pkg::STEP_MAX_ADV
                            : axis_cmd_pkg::STEP_MAX_STD;

  function automatic logic [31:0] rd_mux(input state_t s,
                                         input logic [1:0] busy);
    logic [31:0] r;
    r = '0;
    case (s.addr)
      axis_cmd_pkg::CTRL_OFS: begin
        r[axis_cmd_pkg::CTRL_STEP_BIT] = s.cmd[axis_cmd_pkg::CMD_STEP];
        r[axis_cmd_pkg::CTRL_CANCEL_BIT] = s.cmd[axis_cmd_pkg::CMD_CANCEL];
        r[axis_cmd_pkg::CTRL_PRESET_BIT] = s.cmd[axis_cmd_pkg::CMD_PRESET];
        r[axis_cmd_pkg::CTRL_ADV_BIT] = s.adv;
      end
      axis_cmd_pkg::AXIS_OFS: r[15:0] = s.axis_select;
      axis_cmd_pkg::SLOT_OFS: r[15:0] = s.slot_operand;
      axis_cmd_pkg::VALUE_OFS: r = s.value_operand;
      axis_cmd_pkg::STATUS_OFS: begin
        r[axis_cmd_pkg::ST_IERR_BIT] = s.instr_error_flag;
        r[axis_cmd_pkg::ST_BUSY_LSB +: 2] = busy;
        r[axis_cmd_pkg::ST_ORIGIN_LSB +: 2] = s.origin;
        r[axis_cmd_pkg::ST_AUX_LSB +: 2] = s.aux_on;
      end
      axis_cmd_pkg::STEP_X_OFS: r[15:0] = s.step[0];
      axis_cmd_pkg::STEP_Y_OFS: r[15:0] = s.step[1];
      axis_cmd_pkg::POS_X_OFS: r = s.pos[0];
      axis_cmd_pkg::POS_Y_OFS: r = s.pos[1];
      axis_cmd_pkg::AUX_NUM_X_OFS: r[AUX_W-1:0] = s.aux_num[0];
      axis_cmd_pkg::AUX_NUM_Y_OFS: r[AUX_W-1:0] = s.aux_num[1];
      axis_cmd_pkg::ERR_X_OFS: r[15:0] = s.err[0];
      axis_cmd_pkg::ERR_Y_OFS: r[15:0] = s.err[1];
      default: r = '0;
    endcase
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    err_set = 2'h0;
    s_d.cmd_prev = s_q.cmd;
    // motion side events; cancel below cannot hide a load in the same cycle
    for (int a = 0; a < 2; a++) begin
      if (origin_lost_i[a]) begin
        s_d.origin[a] = 1'b0;
      end
    end
    // command execution on the edge seen this cycle
    if (|rise) begin
      if (!axis_ok) begin
        s_d.instr_error_flag = 1'b1;
      end else begin
        if (rise[axis_cmd_pkg::CMD_STEP]) begin
          if (axis_busy_i[sel]) begin
            s_d.err[sel] = axis_cmd_pkg::ERR_STEP_BUSY;
            err_set[sel] = 1'b1;
          end else if (s_q.value_operand[15:0] < axis_cmd_pkg::STEP_MIN ||
                       s_q.value_operand[15:0] > step_max) begin
            s_d.err[sel] = axis_cmd_pkg::ERR_STEP_RANGE;
            err_set[sel] = 1'b1;
          end else begin
            s_d.step[sel] = s_q.value_operand[15:0];
          end
        end
        if (rise[axis_cmd_pkg::CMD_CANCEL]) begin
          s_d.aux_on[sel] = 1'b0;
          s_d.aux_num[sel] = '0;
        end
        if (rise[axis_cmd_pkg::CMD_PRESET]) begin
          if (axis_busy_i[sel]) begin
            s_d.err[sel] = axis_cmd_pkg::ERR_PRESET_BUSY;
            err_set[sel] = 1'b1;
          end else begin
            s_d.pos[sel] = s_q.value_operand;
            s_d.origin[sel] = 1'b1;
          end
        end
      end
    end
    for (int a = 0; a < 2; a++) begin
      if (aux_load_i[a]) begin
        s_d.aux_on[a] = 1'b1;
        s_d.aux_num[a] = aux_code_i;
      end
    end
    // ahb data phase of a write
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      case (s_q.addr)
        axis_cmd_pkg::CTRL_OFS: begin
          s_d.cmd[axis_cmd_pkg::CMD_STEP] =
            hwdata_i[axis_cmd_pkg::CTRL_STEP_BIT];
          s_d.cmd[axis_cmd_pkg::CMD_CANCEL] =
            hwdata_i[axis_cmd_pkg::CTRL_CANCEL_BIT];
          s_d.cmd[axis_cmd_pkg::CMD_PRESET] =
            hwdata_i[axis_cmd_pkg::CTRL_PRESET_BIT];
          s_d.adv = hwdata_i[axis_cmd_pkg::CTRL_ADV_BIT];
        end
        axis_cmd_pkg::AXIS_OFS: s_d.axis_select = hwdata_i[15:0];
        // slot is kept for readback only: the issuer always writes zero
        axis_cmd_pkg::SLOT_OFS: s_d.slot_operand = hwdata_i[15:0];
        axis_cmd_pkg::VALUE_OFS: s_d.value_operand = hwdata_i;
        axis_cmd_pkg::STATUS_OFS: begin
          // set wins: a new error in this cycle keeps the flag up
          if (hwdata_i[axis_cmd_pkg::ST_IERR_BIT] &&
              !(|rise && !axis_ok)) begin
            s_d.instr_error_flag = 1'b0;
          end
        end
        axis_cmd_pkg::ERR_CLR_OFS: begin
          for (int a = 0; a < 2; a++) begin
            // comparing codes would let a repeat of the same error be lost
            if (hwdata_i[a] && !err_set[a]) begin
              s_d.err[a] = axis_cmd_pkg::ERR_NONE;
            end
          end
        end
        default: s_d.wr_pend = 1'b0;
      endcase
    end
    // reads take one wait state so that a write just before is seen
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.hrdata = rd_mux(s_q, axis_busy_i);
      s_d.hready = 1'b1;
    end else if (addr_phase) begin
      s_d.addr = haddr_i[7:0];
      if (haddr_i[31:8] != 24'h00_0000 || haddr_i[1:0] != 2'h0) begin
        s_d.addr = 8'hFF;
      end
      s_d.wr_pend = hwrite_i;
      s_d.rd_pend = !hwrite_i;
      s_d.hready = hwrite_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.step <= {axis_cmd_pkg::STEP_RST, axis_cmd_pkg::STEP_RST};
      s_q.pos <= {axis_cmd_pkg::POS_RST, axis_cmd_pkg::POS_RST};
      s_q.hrdata <= axis_cmd_pkg::HRDATA_RST;
      s_q.hready <= 1'b1;
      s_q.hresp <= axis_cmd_pkg::HRESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_o = s_q.hrdata;
  assign hreadyout_o = s_q.hready;
  // errors live in the status word and the per-axis error registers, never on the bus: response stays OKAY
  assign hresp_o = s_q.hresp;
  assign aux_code_present_o = s_q.aux_on;
  assign origin_fixed_o = s_q.origin;

  // checks
  logic bad_fire;
  assign bad_fire = |rise && !axis_ok;

  a_edge_only: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_q.cmd_prev[0] && s_q.cmd[0] |=> $stable(s_q.step))
    else $error("step command fired on a held level");

  a_axis_err_flag: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    bad_fire |=> s_q.instr_error_flag)
    else $error("bad axis did not raise the error flag");

  a_axis_suppress: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    bad_fire |=> $stable(s_q.step) && $stable(s_q.pos))
    else $error("bad axis command still acted");

  a_step_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[0] && axis_ok && !axis_busy_i[sel] &&
    s_q.value_operand[15:0] >= 16'h0001 &&
    s_q.value_operand[15:0] <= step_max
    |=> s_q.step[$past(sel)] == $past(s_q.value_operand[15:0]))
    else $error("valid step change not applied");

  a_step_range: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[0] && axis_ok && !axis_busy_i[sel] && !s_q.adv &&
    s_q.value_operand[15:0] == 16'h001F
    |=> s_q.err[$past(sel)] == 16'h01BA)
    else $error("step 31 in standard mode not refused");

  a_step_busy: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[0] && !rise[2] && axis_ok && axis_busy_i[sel]
    |=> s_q.err[$past(sel)] == 16'h01B9 && $stable(s_q.step))
    else $error("busy step change not refused with 441");

  a_cancel_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[1] && axis_ok && !aux_load_i[sel]
    |=> !s_q.aux_on[$past(sel)] && s_q.aux_num[$past(sel)] == '0)
    else $error("aux code not cancelled");

  a_preset_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[2] && axis_ok && !axis_busy_i[sel] && !origin_lost_i[sel]
    |=> s_q.pos[$past(sel)] == $past(s_q.value_operand) &&
        s_q.origin[$past(sel)])
    else $error("preset did not load position and fix origin");

  a_preset_busy: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[2] && axis_ok && axis_busy_i[sel]
    |=> s_q.err[$past(sel)] == 16'h01C3 && $stable(s_q.pos))
    else $error("busy preset not refused with 451");

  a_err_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !(|rise) && !s_q.wr_pend |=> $stable(s_q.err))
    else $error("error code changed without cause");

  a_read_wait: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    addr_phase && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read answer timing wrong");

  c_step_ok: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[0] && axis_ok && !axis_busy_i[sel]);
  c_preset_y: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[2] && s_q.axis_select == 16'h0001);
  c_cancel: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[1] && axis_ok && s_q.aux_on[sel]);
  c_bad_axis: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    bad_fire);
  c_held_level: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_q.cmd[0] && s_q.cmd_prev[0]);

  // a fresh error code must outlive a clear landing in the same cycle
  a_err_set_x: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    err_set[0] |=> s_q.err[0] != 16'h0000)
    else $error("x error code lost to a clear");

  a_err_set_y: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    err_set[1] |=> s_q.err[1] != 16'h0000)
    else $error("y error code lost to a clear");

  a_write_ready: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    addr_phase && hwrite_i |=> hreadyout_o)
    else $error("write answer timing wrong");

  a_cancel_keep: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    bad_fire && !(|aux_load_i)
    |=> $stable(s_q.aux_on) && $stable(s_q.aux_num))
    else $error("bad axis cancel still cleared a code");

  a_err_no_bad: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    bad_fire && !s_q.wr_pend |=> $stable(s_q.err))
    else $error("bad axis command reported an axis error");

  a_step_std_top: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[0] && axis_ok && !axis_busy_i[sel] && !s_q.adv &&
    s_q.value_operand[15:0] == 16'h001E
    |=> s_q.step[$past(sel)] == 16'h001E)
    else $error("step 30 in standard mode refused");

  a_step_adv_top: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[0] && axis_ok && !axis_busy_i[sel] && s_q.adv &&
    s_q.value_operand[15:0] == 16'h0050
    |=> s_q.step[$past(sel)] == 16'h0050)
    else $error("step 80 in advanced mode refused");

  a_held_preset: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    s_q.cmd[2] && s_q.cmd_prev[2] |=> $stable(s_q.pos))
    else $error("preset fired on a held level");

  a_origin_held: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !rise[2] && !(|origin_lost_i) |=> $stable(s_q.origin))
    else $error("origin status changed without cause");

  a_busy_origin: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    rise[2] && axis_ok && axis_busy_i[sel] && !(|origin_lost_i)
    |=> $stable(s_q.origin))
    else $error("busy preset changed origin status");

endmodule

// [testbench/ahb_issuer.sv]
// partner: the issuing controller, a single-word AHB-Lite master
`timescale 1ns/1ps
module ahb_issuer (
  input wire logic mclk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o
);
  logic rdy_s;
  logic [31:0] rd_s;
  // sampled mid-cycle: holds the value seen at the next rising edge, no race
  always @(negedge mclk_i) begin
    rdy_s = hready_i;
    rd_s = hrdata_i;
  end
  initial begin
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end
  // no cycle count is assumed: only the bench watchdog ends a stuck wait
  task automatic wait_ready();
    do begin
      @(posedge mclk_i);
    end while (rdy_s !== 1'b1);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    haddr_o <= {24'h000000, a};
    htrans_o <= axis_cmd_pkg::HTRANS_NONSEQ;
    hwrite_o <= wr;
    wait_ready();
    htrans_o <= 2'h0;
    hwdata_o <= wr ? d : ~hwdata_o;
    wait_ready();
    q = rd_s;
    // released lines: address inverted, data set to the inverse of the written word (all ones after a read)
    hwdata_o <= ~d;
    haddr_o <= ~haddr_o;
  endtask
endmodule

// [testbench/axis_step_mcode_position_cmds_test.sv]
// self-checking bench for axis_cmd: random command stream against a model
`timescale 1ns/1ps
module axis_step_mcode_position_cmds_test;
  logic clk, rst_n, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, lfsr, q;
  logic [1:0] htrans, busy, ld, lost, aux_p, org;
  logic [15:0] code;
  int step_m[2], err_m[2], auxn_m[2], miscompares, num_checks;
  logic [31:0] pos_m[2];
  bit auxp_m[2], org_m[2], ierr_m;
  int step_vals[6] = '{0, 1, 30, 31, 80, 81};
  axis_cmd DUT (.mclk_i(clk), .reset_n_i(rst_n), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .axis_busy_i(busy),
    .aux_load_i(ld), .aux_code_i(code), .origin_lost_i(lost),
    .aux_code_present_o(aux_p), .origin_fixed_o(org));
  ahb_issuer u_host (.mclk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input string nm,
                    input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic check_axis(input int ax);
    logic [7:0] o;
    o = ax ? 8'h04 : 8'h00;
    rd(axis_cmd_pkg::STEP_X_OFS + o, "step", step_m[ax]);
    rd(axis_cmd_pkg::POS_X_OFS + o, "pos", pos_m[ax]);
    rd(axis_cmd_pkg::AUX_NUM_X_OFS + o, "auxnum", auxn_m[ax]);
    rd(axis_cmd_pkg::ERR_X_OFS + o, "err", err_m[ax]);
    rd(axis_cmd_pkg::STATUS_OFS, "status", {25'h0, auxp_m[1], auxp_m[0],
      org_m[1], org_m[0], busy, ierr_m});
    // outputs are looked at mid-cycle, clear of the edge that launches them
    @(negedge clk);
    chk("aux_p", {auxp_m[1], auxp_m[0]}, aux_p);
    chk("org", {org_m[1], org_m[0]}, org);
    chk("hresp", {31'h0, axis_cmd_pkg::HRESP_OKAY}, hresp);
    @(posedge clk);
  endtask
  // the condition bit is released at once so the next command sees a new edge
  task automatic cmd(input int k, input int ax, input logic [31:0] v,
                     input logic adv);
    logic [31:0] m;
    m = {23'h0, adv, 8'h00};
    wr(axis_cmd_pkg::VALUE_OFS, v);
    wr(axis_cmd_pkg::AXIS_OFS, ax);
    wr(axis_cmd_pkg::CTRL_OFS, m | (32'h1 << k));
    wr(axis_cmd_pkg::CTRL_OFS, m);
    if (ax > 1) ierr_m = 1;
    else if (k == 1) begin
      auxp_m[ax] = 0;
      auxn_m[ax] = 0;
    end else if (k == 2) begin
      if (busy[ax]) err_m[ax] = 451;
      else begin
        pos_m[ax] = v;
        org_m[ax] = 1;
      end
    end else if (busy[ax]) err_m[ax] = 441;
    else if (v[15:0] < 1 || v[15:0] > (adv ? 80 : 30)) err_m[ax] = 442;
    else step_m[ax] = v[15:0];
    check_axis(0);
    check_axis(1);
  endtask
  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    busy = 2'h0;
    ld = 2'h0;
    lost = 2'h0;
    code = 16'h0000;
    lfsr = 32'h14AFFAE7;
    step_m = '{1, 1};
    pos_m = '{32'h0, 32'h0};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    check_axis(0);
    check_axis(1);
    rd(8'h40, "unmapped", 32'h0);
    wr(axis_cmd_pkg::SLOT_OFS, 32'h0);
    for (int i = 0; i < 80; i++) begin
      lfsr = next_rand(lfsr);
      @(posedge clk);
      ld <= lfsr[1:0];
      lost <= lfsr[3:2] & {2{lfsr[4]}};
      code <= lfsr[31:16];
      busy <= lfsr[9:8] & {2{lfsr[10]}};
      @(posedge clk);
      ld <= 2'h0;
      lost <= 2'h0;
      for (int a = 0; a < 2; a++) begin
        if (lfsr[a]) auxp_m[a] = 1;
        if (lfsr[a]) auxn_m[a] = lfsr[31:16];
        if (lfsr[a+2] && lfsr[4]) org_m[a] = 0;
      end
      q = next_rand(lfsr);
      cmd(lfsr[12:11] % 3, (lfsr[15:13] == 7) ? 2 + lfsr[16] : lfsr[13],
          (lfsr[12:11] % 3 == 0) ? q % 90 : q, lfsr[20]);
      if (ierr_m) wr(axis_cmd_pkg::STATUS_OFS, 32'h1);
      ierr_m = 0;
      if (lfsr[21]) wr(axis_cmd_pkg::ERR_CLR_OFS, {30'h0, lfsr[22], 1'b1});
      if (lfsr[21]) err_m[0] = 0;
      if (lfsr[21] && lfsr[22]) err_m[1] = 0;
    end
    busy <= 2'h0;
    foreach (step_m[a]) begin
      for (int j = 0; j < 6; j++)
        cmd(0, a, step_vals[j], a);
    end
    cmd(2, 1, 32'h80000000, 1'b0);
    cmd(2, 0, 32'h7FFFFFFF, 1'b0);
    cmd(0, 1, 32'h7, 1'b0);
    wr(axis_cmd_pkg::VALUE_OFS, 32'h9);
    wr(axis_cmd_pkg::CTRL_OFS, 32'h1);
    wr(axis_cmd_pkg::VALUE_OFS, 32'hC);
    wr(axis_cmd_pkg::CTRL_OFS, 32'h1);
    wr(axis_cmd_pkg::CTRL_OFS, 32'h0);
    step_m[1] = 9;
    check_axis(1);
    final_report();
  end
endmodule
